// ### pkg/ssr_pkg.sv
// shared constants for the sequencer status register bank
package ssr_pkg;

  // register addresses on the serial register port
  localparam logic [6:0] ADDR_VENDOR = 7'h12;
  localparam logic [6:0] ADDR_CTL = 7'h13;
  localparam logic [6:0] ADDR_DRV_HI = 7'h14;
  localparam logic [6:0] ADDR_DRV_LO = 7'h15;
  localparam logic [6:0] ADDR_SNS_HI = 7'h16;
  localparam logic [6:0] ADDR_SNS_LO = 7'h17;
  localparam logic [6:0] ADDR_WDT = 7'h18;
  localparam logic [6:0] ADDR_TEST = 7'h19;
  localparam logic [6:0] ADDR_CAUSE = 7'h1A;
  localparam logic [6:0] ADDR_ALT = 7'h20;

  // control pin state field positions
  localparam int CTL_IRQ_BIT = 5;
  localparam int CTL_RST_BIT = 4;
  localparam int CTL_SLP_BIT = 3;
  localparam int CTL_ACT_BIT = 2;

  // watchdog state field positions
  localparam int WDT_OPEN_BIT = 3;
  localparam int WDT_EARLY_BIT = 1;
  localparam int WDT_TIMEOUT_BIT = 0;

  // self test state field positions
  localparam int TST_DONE_BIT = 6;
  localparam int TST_SEC_BIT = 5;

  // last reset cause field positions
  localparam int CAU_RSTREQ_BIT = 7;
  localparam int CAU_WDRST_BIT = 6;
  localparam int CAU_EMERG_BIT = 4;
  localparam int CAU_ACTLOW_BIT = 3;
  localparam int CAU_WDSHDN_BIT = 2;

  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_VENDOR = 8'h00;
  localparam logic [7:0] RST_CAUSE = 8'h00;
  localparam logic [3:0] RST_ALT = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // sequence state encodings
  localparam logic [1:0] SEQ_SHUTDOWN = 2'h0;
  localparam logic [1:0] SEQ_SLEEP = 2'h1;
  localparam logic [1:0] SEQ_INVALID = 2'h2;
  localparam logic [1:0] SEQ_ACTIVE = 2'h3;

  // serial frame layout: rw, 7 address bits, turnaround, 8 data bits
  localparam logic [4:0] FRAME_HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_DATA_FIRST = 5'h09;
  localparam logic [4:0] FRAME_DATA_LAST = 5'h10;
  localparam logic [4:0] FRAME_DONE = 5'h11;

endpackage : ssr_pkg

// ### core/ssr_serial_port.sv
// serial register port logic running on the host's link clock
`timescale 1ns/100ps
module ssr_serial_port
  import ssr_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  input wire logic frame_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic req_tog_o,
  output logic req_write_o,
  output logic [6:0] req_addr_o,
  output logic [7:0] req_wdata_o,
  input wire logic [7:0] rdata_i
);

  logic frame_rst_n;
  logic rd_frame;
  logic [4:0] bit_cnt;
  logic [15:0] shift;
  logic [15:0] next_shift;

  // frame logic is cleared by the frame's own select, since the link
  // clock may stop right after the last bit
  assign frame_rst_n = reset_n_i & ~frame_n_i;
  assign next_shift = {shift[14:0], sdi_i};

  // bit counter and input shifter; rd_frame is local to this frame so a
  // write frame never drives sdo, whatever the last request was
  always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 5'h00;
      shift <= 16'h0000;
      rd_frame <= 1'b0;
    end else begin
      shift <= next_shift;
      if (bit_cnt == FRAME_HDR_LAST) begin
        rd_frame <= ~shift[6];
      end
      if (bit_cnt != FRAME_DONE) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // request word: toggles must survive the frame end, so only the
  // device reset clears them
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_tog_o <= 1'b0;
      req_write_o <= 1'b0;
      req_addr_o <= 7'h00;
      req_wdata_o <= 8'h00;
    end else if (frame_rst_n) begin
      if (bit_cnt == FRAME_HDR_LAST && !shift[6]) begin
        // read: ask for the word now, a turnaround bit gives it time
        req_write_o <= 1'b0;
        req_addr_o <= next_shift[6:0];
        req_tog_o <= ~req_tog_o;
      end else if (bit_cnt == FRAME_DATA_LAST && shift[15]) begin
        req_write_o <= 1'b1;
        req_addr_o <= shift[14:8];
        req_wdata_o <= next_shift[7:0];
        req_tog_o <= ~req_tog_o;
      end
    end
  end

  // read data goes out on the falling edge, msb first; rdata_i is held
  // still by the core from well before the first data bit
  always_ff @(negedge link_clk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else if (rd_frame && bit_cnt >= FRAME_DATA_FIRST &&
                 bit_cnt <= FRAME_DATA_LAST) begin
      sdo_o <= rdata_i[3'(FRAME_DATA_LAST - bit_cnt)];
      sdo_oe_o <= 1'b1;
    end else begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
  end

endmodule : ssr_serial_port

// ### core/ssr_status_regs.sv
// status and configuration register bank of the power sequencer
//
// Contract
// - eight vendor fault flags, one per fault
// - vendor flags clear only by writing one
// - vendor summary is or of flags
// - bit5 low while interrupt output pulled
// - bit4 low while reset output pulled
// - bit3 mirrors sleep input level
// - bit2 mirrors active request input level
// - sequence state codes 00 01 11
// - drive state of twelve enable pins
// - sensed level of twelve enable pins
// - watchdog bit3 shows open window
// - early service flag, cleared on read
// - timeout flag, cleared on read
// - self test done bit
// - single error corrected bit
// - four self test fail bits
// - last cause held until next event
// - emergency shutdown not recorded as cause
// - cause bits for reset request, watchdog reset
// - cause bits emergency input, active low
// - watchdog shutdown bit with powerdown mode
// - forced shutdown code recorded in cause
// - alternate enables loaded once, read only
// - alternate function needs zero slot fields
`timescale 1ns/100ps
module ssr_status_regs
  import ssr_pkg::*;
#(
  parameter int NUM_EN = 12
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  // serial register port on the host's clock
  input wire logic link_clk_i,
  input wire logic frame_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // pin and engine state
  input wire logic interrupt_out_n_i,
  input wire logic reset_out_n_i,
  input wire logic sleep_in_i,
  input wire logic active_request_in_i,
  input wire logic [1:0] sequence_state_i,
  input wire logic [NUM_EN-1:0] enable_drive_bits_i,
  input wire logic [NUM_EN-1:0] enable_sense_i,
  // watchdog events
  input wire logic window_open_i,
  input wire logic early_service_i,
  input wire logic timeout_i,
  // self test results
  input wire logic selftest_done_i,
  input wire logic single_error_corrected_i,
  input wire logic volatile_mem_fail_i,
  input wire logic nonvolatile_mem_fail_i,
  input wire logic logic_test_fail_i,
  input wire logic analog_test_fail_i,
  // reset or shutdown event and its cause
  input wire logic cause_event_i,
  input wire logic emergency_shutdown_i,
  input wire logic reset_request_in_i,
  input wire logic watchdog_reset_cause_i,
  input wire logic emergency_off_in_i,
  input wire logic active_low_cause_i,
  input wire logic watchdog_shutdown_cause_i,
  input wire logic [1:0] forced_shutdown_code_i,
  input wire logic [1:0] watchdog_powerdown_mode_i,
  // vendor faults and alternate function control
  input wire logic [7:0] vendor_fault_set_i,
  output logic vendor_summary_o,
  input wire logic nvm_load_i,
  input wire logic [3:0] nvm_alt_enable_i,
  input wire logic [3:0] slot_nonzero_i,
  output logic [3:0] alt_effective_o
);

  // elaboration check: the register layout is fixed at twelve pins
  if (NUM_EN != 12) begin : g_bad_num_en
    $error("register layout serves exactly twelve enable pins");
  end

  logic req_tog;
  logic req_write;
  logic [6:0] req_addr;
  logic [7:0] req_wdata;
  logic [2:0] tog_sync;
  logic req_pulse;
  logic rd_pulse;
  logic wr_pulse;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [1:0] slp_sync;
  logic [1:0] act_sync;
  logic [NUM_EN-1:0] sns_sync1;
  logic [NUM_EN-1:0] sns_sync2;
  logic early_flag;
  logic timeout_flag;
  logic [7:0] vendor_flags;
  logic [7:0] last_cause;
  logic [7:0] next_cause;
  logic [3:0] alt_enable;
  logic alt_loaded;

  // link side of the register port
  ssr_serial_port u_port (
    .link_clk_i(link_clk_i),
    .reset_n_i(reset_n_i),
    .frame_n_i(frame_n_i),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .req_tog_o(req_tog),
    .req_write_o(req_write),
    .req_addr_o(req_addr),
    .req_wdata_o(req_wdata),
    .rdata_i(rdata)
  );

  // request toggle crossing; the request word is stable by the time the
  // synchronised toggle is seen, so it is sampled without its own sync
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_sync <= 3'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], req_tog};
    end
  end

  assign req_pulse = tog_sync[2] ^ tog_sync[1];
  assign rd_pulse = req_pulse & ~req_write;
  assign wr_pulse = req_pulse & req_write;

  // pin inputs from outside the clock domain
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slp_sync <= 2'h0;
      act_sync <= 2'h0;
      sns_sync1 <= '0;
      sns_sync2 <= '0;
    end else begin
      slp_sync <= {slp_sync[0], sleep_in_i};
      act_sync <= {act_sync[0], active_request_in_i};
      sns_sync1 <= enable_sense_i;
      sns_sync2 <= sns_sync1;
    end
  end

  // vendor fault flags, a new fault beats a clear in the same cycle
  for (genvar i = 0; i < 8; i++) begin : g_vendor
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        vendor_flags[i] <= RST_VENDOR[i];
      end else if (vendor_fault_set_i[i]) begin
        vendor_flags[i] <= 1'b1;
      end else if (wr_pulse && req_addr == ADDR_VENDOR && req_wdata[i]) begin
        vendor_flags[i] <= 1'b0;
      end
    end
  end

  assign vendor_summary_o = |vendor_flags;

  // watchdog violation flags, cleared by reading the watchdog register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      early_flag <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      if (early_service_i) begin
        early_flag <= 1'b1;
      end else if (rd_pulse && req_addr == ADDR_WDT) begin
        early_flag <= 1'b0;
      end
      if (timeout_i) begin
        timeout_flag <= 1'b1;
      end else if (rd_pulse && req_addr == ADDR_WDT) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // new cause word; the watchdog mode replaces the forced code
  always_comb begin
    next_cause = 8'h00;
    next_cause[CAU_RSTREQ_BIT] = reset_request_in_i;
    next_cause[CAU_WDRST_BIT] = watchdog_reset_cause_i;
    next_cause[CAU_EMERG_BIT] = emergency_off_in_i;
    next_cause[CAU_ACTLOW_BIT] = active_low_cause_i;
    next_cause[CAU_WDSHDN_BIT] = watchdog_shutdown_cause_i;
    if (watchdog_shutdown_cause_i) begin
      next_cause[1:0] = watchdog_powerdown_mode_i;
    end else begin
      next_cause[1:0] = forced_shutdown_code_i;
    end
  end

  // last cause, kept until the next recorded reset or shutdown
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_cause <= RST_CAUSE;
    end else if (cause_event_i && !emergency_shutdown_i) begin
      last_cause <= next_cause;
    end
  end

  // alternate enables, taken once from nvm then frozen
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alt_enable <= RST_ALT;
      alt_loaded <= 1'b0;
    end else if (nvm_load_i && !alt_loaded) begin
      alt_enable <= nvm_alt_enable_i;
      alt_loaded <= 1'b1;
    end
  end

  // a pin with any sequencing slot stays a sequencing pin
  assign alt_effective_o = alt_enable & ~slot_nonzero_i;

  // read multiplexer, reserved bits and unknown addresses give zero
  always_comb begin
    next_rdata = READ_UNMAPPED;
    case (req_addr)
      ADDR_VENDOR: begin
        next_rdata = vendor_flags;
      end
      ADDR_CTL: begin
        next_rdata[CTL_IRQ_BIT] = interrupt_out_n_i;
        next_rdata[CTL_RST_BIT] = reset_out_n_i;
        next_rdata[CTL_SLP_BIT] = slp_sync[1];
        next_rdata[CTL_ACT_BIT] = act_sync[1];
        next_rdata[1:0] = sequence_state_i;
      end
      ADDR_DRV_HI: begin
        next_rdata[3:0] = enable_drive_bits_i[11:8];
      end
      ADDR_DRV_LO: begin
        next_rdata = enable_drive_bits_i[7:0];
      end
      ADDR_SNS_HI: begin
        next_rdata[3:0] = sns_sync2[11:8];
      end
      ADDR_SNS_LO: begin
        next_rdata = sns_sync2[7:0];
      end
      ADDR_WDT: begin
        next_rdata[WDT_OPEN_BIT] = window_open_i;
        next_rdata[WDT_EARLY_BIT] = early_flag;
        next_rdata[WDT_TIMEOUT_BIT] = timeout_flag;
      end
      ADDR_TEST: begin
        next_rdata[TST_DONE_BIT] = selftest_done_i;
        next_rdata[TST_SEC_BIT] = single_error_corrected_i;
        next_rdata[3:0] = {volatile_mem_fail_i, nonvolatile_mem_fail_i,
                           logic_test_fail_i, analog_test_fail_i};
      end
      ADDR_CAUSE: begin
        next_rdata = last_cause;
      end
      ADDR_ALT: begin
        next_rdata[3:0] = alt_enable;
      end
      default: begin
        next_rdata = READ_UNMAPPED;
      end
    endcase
  end

  // read word is captured once per read and held for the link side;
  // writes never touch it, and every register but the vendor flags ignores writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata <= RST_STATUS;
    end else if (rd_pulse) begin
      rdata <= next_rdata;
    end
  end

  // checks on the system clock
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_wdt_read;
    rd_pulse && req_addr == ADDR_WDT;
  endsequence

  sequence s_ctl_read;
    rd_pulse && req_addr == ADDR_CTL;
  endsequence

  chk_vendor_set: assert property (
    vendor_fault_set_i != 8'h00 |=> vendor_summary_o &&
      ((vendor_flags & $past(vendor_fault_set_i)) == $past(vendor_fault_set_i)))
    else $error("vendor fault not flagged");

  chk_vendor_clear: assert property (
    wr_pulse && req_addr == ADDR_VENDOR && vendor_fault_set_i == 8'h00
    |=> vendor_flags == ($past(vendor_flags) & ~$past(req_wdata)))
    else $error("vendor clear wrong");

  chk_vendor_keep: assert property (
    !(wr_pulse && req_addr == ADDR_VENDOR) && vendor_fault_set_i == 8'h00
    |=> $stable(vendor_flags))
    else $error("vendor flags changed without cause");

  chk_vendor_sum: assert property (
    vendor_summary_o == (vendor_flags != 8'h00))
    else $error("vendor summary wrong");

  chk_ctl_pins: assert property (
    s_ctl_read |=> rdata[CTL_IRQ_BIT] == $past(interrupt_out_n_i) &&
      rdata[CTL_RST_BIT] == $past(reset_out_n_i) && rdata[7:6] == 2'h0)
    else $error("control pin state wrong");

  chk_early_set: assert property (
    early_service_i |=> early_flag ##1 (early_flag || $past(rd_pulse)))
    else $error("early service flag lost");

  chk_wdt_clear: assert property (
    s_wdt_read ##0 (!early_service_i && !timeout_i)
    |=> !early_flag && !timeout_flag && rdata[2] == 1'b0)
    else $error("watchdog flags not cleared by read");

  chk_timeout_set: assert property (
    timeout_i ##0 s_wdt_read |=> timeout_flag)
    else $error("timeout lost against read");

  chk_cause_hold: assert property (
    !cause_event_i || emergency_shutdown_i |=> $stable(last_cause))
    else $error("last cause changed without event");

  chk_cause_code: assert property (
    cause_event_i && !emergency_shutdown_i |=> last_cause[1:0] ==
      ($past(watchdog_shutdown_cause_i) ? $past(watchdog_powerdown_mode_i)
       : $past(forced_shutdown_code_i)) && last_cause[5] == 1'b0)
    else $error("shutdown code wrong");

  chk_alt_frozen: assert property (
    alt_loaded |=> $stable(alt_enable))
    else $error("alternate enables changed after load");

  chk_alt_lock: assert property (
    (alt_effective_o & slot_nonzero_i) == 4'h0 &&
      (alt_effective_o == 4'h0 || alt_loaded))
    else $error("alternate function on a sequencing pin");

endmodule : ssr_status_regs

// ### test/ssr_host_model.sv
// host side model of the serial register port, one byte per frame
`timescale 1ns/100ps
module ssr_host_model (
  output logic link_clk_o,
  output logic frame_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  localparam real HALF = 62.5;

  // link clock idles low and stands still between frames
  initial begin
    link_clk_o = 1'b0;
    frame_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // rw, address, turnaround, data; data bit changes while clock is low
  task automatic xfer(input logic wr, input logic [6:0] addr,
                      input logic [7:0] wd, output logic [7:0] rd);
    logic [16:0] word;
    word = {wr, addr, 1'b0, wd};
    rd = 8'h00;
    #3.7;
    frame_n_o = 1'b0;
    for (int i = 16; i >= 0; i--) begin
      sdi_o = word[i];
      #(HALF);
      link_clk_o = 1'b1;
      // a bit sampled without the device driving counts as unknown
      if (i <= 7) rd[i] = sdo_oe_i ? sdo_i : 1'bx;
      #(HALF);
      link_clk_o = 1'b0;
    end
    #(HALF);
    frame_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale value
    #(2 * HALF);
  endtask : xfer
endmodule : ssr_host_model

// ### test/sequencer_status_regs_bench.sv
// self-checking bench for the sequencer status register bank
`timescale 1ns/100ps
module sequencer_status_regs_bench
  import ssr_pkg::*;
;
  logic clk_i, reset_n_i, lclk, frame_n, sdi, sdo, sdo_oe;
  logic irq_n, rst_n, slp, act, wopen, early, tmo, cev, emsd;
  logic done, sec, vm, nvm, lt, an, rreq, wdr, emin, actl, wds;
  logic [1:0] seq, fcode, pdmd;
  logic [11:0] drv, sns;
  logic [7:0] vset;
  logic vsum, nload;
  logic [3:0] nalt, slotnz, alteff;
  int err_total, check_count;

  ssr_host_model host (.link_clk_o(lclk), .frame_n_o(frame_n),
    .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  ssr_status_regs #(.NUM_EN(12)) uut (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .link_clk_i(lclk), .frame_n_i(frame_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .interrupt_out_n_i(irq_n), .reset_out_n_i(rst_n), .sleep_in_i(slp),
    .active_request_in_i(act), .sequence_state_i(seq),
    .enable_drive_bits_i(drv), .enable_sense_i(sns),
    .window_open_i(wopen), .early_service_i(early), .timeout_i(tmo),
    .selftest_done_i(done), .single_error_corrected_i(sec),
    .volatile_mem_fail_i(vm), .nonvolatile_mem_fail_i(nvm),
    .logic_test_fail_i(lt), .analog_test_fail_i(an),
    .cause_event_i(cev), .emergency_shutdown_i(emsd),
    .reset_request_in_i(rreq), .watchdog_reset_cause_i(wdr),
    .emergency_off_in_i(emin), .active_low_cause_i(actl),
    .watchdog_shutdown_cause_i(wds), .forced_shutdown_code_i(fcode),
    .watchdog_powerdown_mode_i(pdmd), .vendor_fault_set_i(vset),
    .vendor_summary_o(vsum), .nvm_load_i(nload),
    .nvm_alt_enable_i(nalt), .slot_nonzero_i(slotnz),
    .alt_effective_o(alteff));

  // 100 MHz system clock
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd_chk(input string what, input logic [6:0] a,
                        input logic [7:0] exp);
    logic [7:0] v;
    host.xfer(1'b0, a, 8'h00, v);
    step(1); // realign stimulus to the system clock
    check(what, exp, v);
  endtask : rd_chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    host.xfer(1'b1, a, d, v);
    step(1);
  endtask : wr

  task automatic pulse_ev();
    cev = 1'b1;
    step(1);
    cev = 1'b0;
    step(2);
  endtask : pulse_ev

  task automatic t_reset();
    logic [6:0] al [11];
    al = '{7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19,
           7'h1A, 7'h20, 7'h05};
    foreach (al[i]) rd_chk("reset value", al[i], 8'h00);
    check("summary", 8'h00, {7'h00, vsum});
    check("alt eff", 8'h00, {4'h0, alteff});
    $display("test reset done");
  endtask : t_reset

  task automatic t_ctl();
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      irq_n = k[0];
      rst_n = ~k[0];
      slp = k[1];
      act = ~k[1];
      seq = k;
      step(4);
      wr(ADDR_CTL, 8'hFF);
      rd_chk("ctl", ADDR_CTL, {2'h0, k[0], ~k[0], k[1], ~k[1], k});
    end
    $display("test ctl done");
  endtask : t_ctl

  task automatic t_pins();
    drv = 12'hA5C;
    sns = 12'h3C9;
    step(4);
    rd_chk("drv hi", ADDR_DRV_HI, 8'h0A);
    rd_chk("drv lo", ADDR_DRV_LO, 8'h5C);
    rd_chk("sns hi", ADDR_SNS_HI, 8'h03);
    rd_chk("sns lo", ADDR_SNS_LO, 8'hC9);
    $display("test pins done");
  endtask : t_pins

  task automatic t_wdt();
    wopen = 1'b1;
    early = 1'b1;
    tmo = 1'b1;
    step(1);
    early = 1'b0;
    tmo = 1'b0;
    rd_chk("wdt set", ADDR_WDT, 8'h0B);
    rd_chk("wdt clr", ADDR_WDT, 8'h08);
    wopen = 1'b0;
    early = 1'b1;
    step(1);
    early = 1'b0;
    rd_chk("wdt early", ADDR_WDT, 8'h02);
    rd_chk("wdt empty", ADDR_WDT, 8'h00);
    $display("test wdt done");
  endtask : t_wdt

  task automatic t_test();
    done = 1'b1;
    sec = 1'b1;
    vm = 1'b1;
    an = 1'b1;
    step(2);
    rd_chk("test a", ADDR_TEST, 8'h69);
    {done, sec, vm, an, nvm, lt} = 6'b000011;
    step(2);
    rd_chk("test b", ADDR_TEST, 8'h06);
    $display("test selftest done");
  endtask : t_test

  task automatic t_cause();
    rreq = 1'b1;
    fcode = 2'h2;
    pulse_ev();
    rd_chk("cause rreq", ADDR_CAUSE, 8'h82);
    {rreq, fcode, emsd, emin} = 5'b00011;
    pulse_ev();
    rd_chk("cause emerg", ADDR_CAUSE, 8'h82);
    emsd = 1'b0;
    actl = 1'b1;
    pulse_ev();
    rd_chk("cause pins", ADDR_CAUSE, 8'h18);
    {emin, actl, wdr, wds, fcode, pdmd} = 8'b00110111;
    pulse_ev();
    rd_chk("cause wdt", ADDR_CAUSE, 8'h47);
    $display("test cause done");
  endtask : t_cause

  task automatic t_vendor();
    vset = 8'hA5;
    step(1);
    vset = 8'h00;
    step(1);
    check("summary set", 8'h01, {7'h00, vsum});
    rd_chk("vendor set", ADDR_VENDOR, 8'hA5);
    wr(ADDR_VENDOR, 8'h05);
    rd_chk("vendor w1c", ADDR_VENDOR, 8'hA0);
    wr(ADDR_VENDOR, 8'h0F);
    rd_chk("vendor zero", ADDR_VENDOR, 8'hA0);
    wr(ADDR_VENDOR, 8'hA0);
    rd_chk("vendor clr", ADDR_VENDOR, 8'h00);
    check("summary clr", 8'h00, {7'h00, vsum});
    $display("test vendor done");
  endtask : t_vendor

  task automatic t_alt();
    nalt = 4'hB;
    slotnz = 4'h2;
    nload = 1'b1;
    step(1);
    nload = 1'b0;
    nalt = 4'h4;
    step(2);
    check("alt locked", 8'h09, {4'h0, alteff});
    nload = 1'b1;
    step(1);
    nload = 1'b0;
    wr(ADDR_ALT, 8'h00);
    rd_chk("alt reg", ADDR_ALT, 8'h0B);
    slotnz = 4'h0;
    step(1);
    check("alt free", 8'h0B, {4'h0, alteff});
    $display("test alt done");
  endtask : t_alt

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // main sequence: inputs quiet at time zero, reset, then each test
  initial begin
    err_total = 0;
    check_count = 0;
    reset_n_i = 1'b0;
    {irq_n, rst_n, slp, act, wopen, early, tmo, cev, emsd} = 9'h000;
    {done, sec, vm, nvm, lt, an, rreq, wdr, emin, actl, wds} = 11'h000;
    {seq, fcode, pdmd, drv, sns, vset} = 38'h0;
    {nload, nalt, slotnz} = 9'h000;
    step(16);
    reset_n_i = 1'b1;
    step(3);
    t_reset();
    t_ctl();
    t_pins();
    t_wdt();
    t_test();
    t_cause();
    t_vendor();
    t_alt();
    close_out();
  end

  // about forty frames of 2.3 us each; stop well past that
  initial begin
    #300000;
    err_total++;
    close_out();
  end
endmodule : sequencer_status_regs_bench
